/* reset_cause_pkg.sv */
/*
 * Constants and carrier types for the reset cause recorder: register
 * indices, bit positions, reset values and the event bundle.
 * Assumes APB with 32-bit data; each register index maps to byte address index*4.
 */
package reset_cause_pkg;

    // ========================================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] INDEX_BROWNOUT_CONTROL = 10'h191;
    localparam logic [9:0] INDEX_RESET_CAUSE_FLAGS = 10'h192;
    localparam logic [9:0] INDEX_VIOLATION_FLAGS = 10'h193;
    localparam logic [9:0] INDEX_SLEEP_STATUS = 10'h194;
    localparam logic [9:0] INDEX_RESET_CONTROL = 10'h195;
    localparam int PADDR_WIDTH = 12;
    localparam int WORD_LSB = 2;

    // ========================================================================
    // reset_cause_flags bit positions
    localparam int BIT_STACK_OVERFLOW = 7;
    localparam int BIT_STACK_UNDERFLOW = 6;
    localparam int BIT_WINDOW_VIOLATION = 5;
    localparam int BIT_WATCHDOG_RESET = 4;
    localparam int BIT_EXTERNAL_PIN = 3;
    localparam int BIT_RESET_INSTRUCTION = 2;
    localparam int BIT_POWER_ON = 1;
    localparam int BIT_BROWNOUT = 0;

    // other register bit positions
    localparam int BIT_SOFTWARE_BROWNOUT_ENABLE = 7;
    localparam int BIT_BROWNOUT_READY = 0;
    localparam int BIT_MEMORY_VIOLATION = 1;
    localparam int BIT_TIMEOUT = 4;
    localparam int BIT_POWERDOWN = 3;
    localparam int BIT_STACK_RESET_ENABLE = 0;
    localparam int BIT_PROTECTED_AREA_ENABLE = 1;

    // ========================================================================
    // reset values: power-on pattern and brown-out forced bits
    localparam logic [7:0] FLAGS_POWER_ON = 8'h3D;
    localparam logic [7:0] FLAGS_BROWNOUT_MASK = 8'hFD;
    localparam logic [7:0] FLAGS_BROWNOUT_VALUE = 8'h3C;
    localparam logic [1:0] RESET_CONTROL_DEFAULT = 2'h1;

    // brownout_mode_select encodings
    localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
    localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;

    // restart addresses
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] INTERRUPT_VECTOR = 16'h0004;

    // on-chip event pulses, one cycle each, on pclk
    typedef struct packed {
        logic brownout;
        logic watchdog_timeout;
        logic window_violation;
        logic watchdog_wake;
        logic interrupt_wake;
        logic reset_instruction;
        logic stack_overflow;
        logic stack_underflow;
    } reset_events_type;

endpackage : reset_cause_pkg

/* reset_cause_recorder.sv */
/*
 * Reset cause recorder: detects memory execution violations, records the
 * cause of every reset in sticky flags reachable over APB, tracks the
 * sleep status bits and drives the brown-out enable.
 * Assumes presetn is the power-on reset, event pulses come from pclk logic,
 * and the external reset pin and brown-out ready level are asynchronous.
 */
`timescale 1ns/1ps
module reset_cause_recorder
    import reset_cause_pkg::*;
#(
    parameter int ADDR_WIDTH = 16,
    parameter int PROGRAM_WORDS = 4096,
    parameter int PROTECTED_WORDS = 128
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_reset_pin_n,
    input wire logic brownout_circuit_ready,
    input wire logic [1:0] brownout_mode_select,
    input wire reset_events_type events,
    input wire logic sleeping,
    input wire logic global_interrupt_enable,
    input wire logic fetch_execute,
    input wire logic [ADDR_WIDTH-1:0] fetch_address,
    output logic device_reset_request,
    output logic resume_next,
    output logic interrupt_vector_load,
    output logic [15:0] restart_address,
    output logic brownout_enable
);

    // ========================================================================
    // storage
    logic [7:0] reset_cause_flags;
    logic memory_violation_flag;
    logic timeout_status;
    logic powerdown_status;
    logic software_brownout_enable;
    logic [1:0] reset_control;
    logic pin_sync_first;
    logic pin_sync_second;
    logic pin_level_last;
    logic ready_sync_first;
    logic brownout_ready;

    // ========================================================================
    // synchronisers for pin and analog inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync_first <= 1'b1;
            pin_sync_second <= 1'b1;
            pin_level_last <= 1'b1;
            ready_sync_first <= 1'b0;
            brownout_ready <= 1'b0;
        end
        else
        begin
            pin_sync_first <= external_reset_pin_n;
            pin_sync_second <= pin_sync_first;
            pin_level_last <= pin_sync_second;
            ready_sync_first <= brownout_circuit_ready;
            brownout_ready <= ready_sync_first;
        end
    end

    // ========================================================================
    // event decode
    logic stack_reset_enable;
    logic protected_area_enable;
    logic pin_reset;
    logic fetch_invalid;
    logic memory_violation;
    logic stack_overflow_reset;
    logic stack_underflow_reset;
    logic any_reset;

    assign stack_reset_enable = reset_control[BIT_STACK_RESET_ENABLE];
    assign protected_area_enable = reset_control[BIT_PROTECTED_AREA_ENABLE];
    // falling edge of the synchronised pin
    assign pin_reset = pin_level_last & ~pin_sync_second;
    // beyond memory, or inside the top protected area when enabled
    assign fetch_invalid = (32'(fetch_address) >= 32'(PROGRAM_WORDS))
        | (protected_area_enable
           & (32'(fetch_address) >= 32'(PROGRAM_WORDS - PROTECTED_WORDS)));
    assign memory_violation = fetch_execute & fetch_invalid;
    assign stack_overflow_reset = events.stack_overflow & stack_reset_enable;
    assign stack_underflow_reset = events.stack_underflow & stack_reset_enable;
    assign any_reset = events.brownout | events.watchdog_timeout | events.window_violation
        | events.reset_instruction | stack_overflow_reset | stack_underflow_reset
        | pin_reset | memory_violation;

    // event sources other than brown-out drive each flag only toward its active level
    logic [7:0] hw_clear;
    logic [7:0] hw_set;

    always_comb
    begin
        hw_clear = 8'h00;
        hw_set = 8'h00;
        hw_clear[BIT_WATCHDOG_RESET] = events.watchdog_timeout;
        hw_clear[BIT_WINDOW_VIOLATION] = events.window_violation;
        hw_clear[BIT_EXTERNAL_PIN] = pin_reset;
        hw_clear[BIT_RESET_INSTRUCTION] = events.reset_instruction;
        hw_set[BIT_STACK_OVERFLOW] = stack_overflow_reset;
        hw_set[BIT_STACK_UNDERFLOW] = stack_underflow_reset;
    end

    // ========================================================================
    // APB decode
    logic [9:0] word_index;
    logic access;
    logic write_take;
    logic mapped;

    assign word_index = paddr[PADDR_WIDTH-1:WORD_LSB];
    assign access = psel & penable & pready;
    assign write_take = access & pwrite;

    always_comb
    begin
        unique case (word_index)
            INDEX_BROWNOUT_CONTROL,
            INDEX_RESET_CAUSE_FLAGS,
            INDEX_VIOLATION_FLAGS,
            INDEX_SLEEP_STATUS,
            INDEX_RESET_CONTROL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    logic write_flags;
    logic write_violation;
    logic write_brownout;
    logic write_control;

    assign write_flags = write_take & (word_index == INDEX_RESET_CAUSE_FLAGS);
    assign write_violation = write_take & (word_index == INDEX_VIOLATION_FLAGS);
    assign write_brownout = write_take & (word_index == INDEX_BROWNOUT_CONTROL);
    assign write_control = write_take & (word_index == INDEX_RESET_CONTROL);

    // ========================================================================
    // cause flags: power-on via presetn, brown-out forces its pattern
    logic [7:0] next_flags;

    always_comb
    begin
        next_flags = write_flags ? pwdata[7:0] : reset_cause_flags;
        next_flags = (next_flags & ~hw_clear) | hw_set;
        if (events.brownout)
        begin
            next_flags = (next_flags & ~FLAGS_BROWNOUT_MASK)
                | (FLAGS_BROWNOUT_VALUE & FLAGS_BROWNOUT_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_cause_flags <= FLAGS_POWER_ON;
        end
        else
        begin
            reset_cause_flags <= next_flags;
        end
    end

    // memory violation flag: cleared by violation, pin reset while awake and without brown-out sets it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            memory_violation_flag <= 1'b1;
        end
        else if (memory_violation)
        begin
            memory_violation_flag <= 1'b0;
        end
        else if (pin_reset & ~sleeping & ~events.brownout)
        begin
            memory_violation_flag <= 1'b1;
        end
        else if (write_violation)
        begin
            memory_violation_flag <= pwdata[BIT_MEMORY_VIOLATION];
        end
    end

    // ========================================================================
    // sleep status bits, read-only to software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timeout_status <= 1'b1;
            powerdown_status <= 1'b1;
        end
        else if (events.brownout)
        begin
            timeout_status <= 1'b1;
            powerdown_status <= 1'b1;
        end
        else if (pin_reset & sleeping)
        begin
            timeout_status <= 1'b1;
            powerdown_status <= 1'b0;
        end
        else if (pin_reset)
        begin
            timeout_status <= timeout_status;
        end
        else if (events.watchdog_timeout | events.window_violation)
        begin
            timeout_status <= 1'b0;
        end
        else if (events.watchdog_wake)
        begin
            timeout_status <= 1'b0;
            powerdown_status <= 1'b0;
        end
        else if (events.interrupt_wake)
        begin
            timeout_status <= 1'b1;
            powerdown_status <= 1'b0;
        end
    end

    // ========================================================================
    // brown-out control and reset control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            software_brownout_enable <= 1'b1;
        end
        else if (events.brownout)
        begin
            software_brownout_enable <= 1'b1;
        end
        else if (write_brownout)
        begin
            software_brownout_enable <= pwdata[BIT_SOFTWARE_BROWNOUT_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_control <= RESET_CONTROL_DEFAULT;
        end
        else if (write_control)
        begin
            reset_control <= pwdata[1:0];
        end
    end

    // effective brown-out enable from mode and software bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            brownout_enable <= 1'b0;
        end
        else
        begin
            unique case (brownout_mode_select)
                MODE_ALWAYS_ON: brownout_enable <= 1'b1;
                MODE_OFF_IN_SLEEP: brownout_enable <= ~sleeping;
                MODE_SOFTWARE: brownout_enable <= software_brownout_enable;
                MODE_ALWAYS_OFF: brownout_enable <= 1'b0;
            endcase
        end
    end

    // ========================================================================
    // core-facing reset and restart outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            device_reset_request <= 1'b0;
            resume_next <= 1'b0;
            interrupt_vector_load <= 1'b0;
            restart_address <= RESET_VECTOR;
        end
        else
        begin
            device_reset_request <= any_reset;
            resume_next <= ~any_reset & (events.watchdog_wake | events.interrupt_wake);
            interrupt_vector_load <= ~any_reset & ~events.watchdog_wake
                & events.interrupt_wake & global_interrupt_enable;
            if (any_reset)
            begin
                restart_address <= RESET_VECTOR;
            end
            else if (events.interrupt_wake & global_interrupt_enable)
            begin
                restart_address <= INTERRUPT_VECTOR;
            end
        end
    end

    // ========================================================================
    // APB answer: one wait state, registered read data
    logic [31:0] read_word;

    always_comb
    begin
        read_word = 32'h0000_0000;
        unique case (word_index)
            INDEX_BROWNOUT_CONTROL:
            begin
                read_word[BIT_SOFTWARE_BROWNOUT_ENABLE] = software_brownout_enable;
                read_word[BIT_BROWNOUT_READY] = brownout_ready;
            end
            INDEX_RESET_CAUSE_FLAGS: read_word[7:0] = reset_cause_flags;
            INDEX_VIOLATION_FLAGS: read_word[BIT_MEMORY_VIOLATION] = memory_violation_flag;
            INDEX_SLEEP_STATUS:
            begin
                read_word[BIT_TIMEOUT] = timeout_status;
                read_word[BIT_POWERDOWN] = powerdown_status;
            end
            INDEX_RESET_CONTROL: read_word[1:0] = reset_control;
            default: read_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite)
            begin
                prdata <= read_word;
            end
        end
    end

endmodule : reset_cause_recorder

/* reset_cause_recorder_chk.sv */
/*
 * Port checker for the reset cause recorder: bus timing, restarts, wakes.
 * Assumes one pclk domain and presetn as its asynchronous reset.
 */
`timescale 1ns/1ps
module reset_cause_recorder_chk
    import reset_cause_pkg::*;
#(
    parameter int ADDR_WIDTH = 16,
    parameter int PROGRAM_WORDS = 4096,
    parameter int PROTECTED_WORDS = 128
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] brownout_mode_select,
    input wire reset_events_type events,
    input wire logic global_interrupt_enable,
    input wire logic fetch_execute,
    input wire logic [ADDR_WIDTH-1:0] fetch_address,
    input wire logic device_reset_request,
    input wire logic resume_next,
    input wire logic interrupt_vector_load,
    input wire logic [15:0] restart_address,
    input wire logic brownout_enable
);
    // ========================================================================
    // bus sequences
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] index;
    // word index of the current address
    assign index = paddr[PADDR_WIDTH-1:WORD_LSB];
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_unmapped;
        s_access ##0 (index < INDEX_BROWNOUT_CONTROL || index > INDEX_RESET_CONTROL);
    endsequence

    // ========================================================================
    // assertions
    a_ready_wait: assert property (s_access |=> pready)
        else $error("pready missing after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    // read data only reloads on reads, so a refused write leaves it alone
    a_unmapped_err: assert property (s_unmapped |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_instr_restart: assert property (events.reset_instruction |=>
        device_reset_request && restart_address == RESET_VECTOR)
        else $error("reset instruction did not restart at zero");
    a_invalid_fetch: assert property (fetch_execute && fetch_address >= PROGRAM_WORDS
        |=> device_reset_request)
        else $error("fetch beyond memory did not reset");
    a_vector_load: assert property (events.interrupt_wake && global_interrupt_enable
        |=> interrupt_vector_load && restart_address == INTERRUPT_VECTOR)
        else $error("enabled interrupt wake did not vector");
    a_plain_wake: assert property ((events.watchdog_wake ||
        (events.interrupt_wake && !global_interrupt_enable))
        |=> resume_next && !interrupt_vector_load)
        else $error("plain wake did not resume at next address");
    a_bo_forced_on: assert property (brownout_mode_select == MODE_ALWAYS_ON
        |=> brownout_enable)
        else $error("brown-out detector off in always-on mode");
    a_bo_forced_off: assert property (brownout_mode_select == MODE_ALWAYS_OFF
        |=> !brownout_enable)
        else $error("brown-out detector on in always-off mode");
endmodule : reset_cause_recorder_chk

bind reset_cause_recorder reset_cause_recorder_chk #(.ADDR_WIDTH(ADDR_WIDTH),
    .PROGRAM_WORDS(PROGRAM_WORDS), .PROTECTED_WORDS(PROTECTED_WORDS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownout_mode_select(brownout_mode_select), .events(events),
    .global_interrupt_enable(global_interrupt_enable), .fetch_execute(fetch_execute),
    .fetch_address(fetch_address), .device_reset_request(device_reset_request),
    .resume_next(resume_next), .interrupt_vector_load(interrupt_vector_load),
    .restart_address(restart_address), .brownout_enable(brownout_enable));

/* core_model.sv */
/*
 * Model of the core and on-chip reset sources facing the recorder.
 * Assumes it is driven by task calls from the testbench, on pclk edges.
 */
`timescale 1ns/1ps
module core_model
    import reset_cause_pkg::*;
#(
    parameter int ADDR_WIDTH = 16
)
(
    input wire logic pclk,
    output reset_events_type events,
    output logic sleeping,
    output logic global_interrupt_enable,
    output logic fetch_execute,
    output logic [ADDR_WIDTH-1:0] fetch_address,
    output logic external_reset_pin_n,
    output logic brownout_circuit_ready
);
    // ========================================================================
    // idle levels; pin idles high through its pull-up
    initial
    begin
        events = '0;
        sleeping = 1'b0;
        global_interrupt_enable = 1'b0;
        fetch_execute = 1'b0;
        fetch_address = '0;
        external_reset_pin_n = 1'b1;
        brownout_circuit_ready = 1'b0;
    end

    // one-cycle event pulse
    task pulse(input reset_events_type e);
        @(posedge pclk);
        events <= e;
        @(posedge pclk);
        events <= '0;
    endtask : pulse

    // one executed fetch; the address bus shows garbage afterwards
    task fetch(input logic [ADDR_WIDTH-1:0] a);
        @(posedge pclk);
        fetch_execute <= 1'b1;
        fetch_address <= a;
        @(posedge pclk);
        fetch_execute <= 1'b0;
        fetch_address <= ~a;
    endtask : fetch

    // pin held low long enough to pass the synchroniser
    task pin_reset();
        @(posedge pclk);
        external_reset_pin_n <= 1'b0;
        repeat (6) @(posedge pclk);
        external_reset_pin_n <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : pin_reset

    // core sleep, interrupt enable and detector ready levels
    task set_state(input logic slp, input logic ie, input logic rdy);
        @(posedge pclk);
        sleeping <= slp;
        global_interrupt_enable <= ie;
        brownout_circuit_ready <= rdy;
    endtask : set_state
endmodule : core_model

/* testbench.sv */
/*
 * Self-checking bench for the reset cause recorder over APB.
 * Assumes core_model on the event side and the bound port checker.
 */
`timescale 1ns/1ps
module testbench
    import reset_cause_pkg::*;
;
    localparam int PW = 4096;
    localparam int PA = 128;
    localparam logic [11:0] A_BOCON = {INDEX_BROWNOUT_CONTROL, 2'b00};
    localparam logic [11:0] A_FLAGS = {INDEX_RESET_CAUSE_FLAGS, 2'b00};
    localparam logic [11:0] A_VIOL = {INDEX_VIOLATION_FLAGS, 2'b00};
    localparam logic [11:0] A_SLEEP = {INDEX_SLEEP_STATUS, 2'b00};
    localparam logic [11:0] A_CTRL = {INDEX_RESET_CONTROL, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] brownout_mode_select = 2'h1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, res, vec;
    logic device_reset_request, resume_next, interrupt_vector_load, brownout_enable;
    logic [15:0] restart_address, ra;
    reset_events_type events;
    logic sleeping, global_interrupt_enable, fetch_execute;
    logic external_reset_pin_n, brownout_circuit_ready;
    logic [15:0] fetch_address;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    // ========================================================================
    // clock, design and core
    always #5 pclk = ~pclk;
    reset_cause_recorder #(.ADDR_WIDTH(16), .PROGRAM_WORDS(PW), .PROTECTED_WORDS(PA)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .external_reset_pin_n, .brownout_circuit_ready, .brownout_mode_select,
        .events, .sleeping, .global_interrupt_enable, .fetch_execute, .fetch_address,
        .device_reset_request, .resume_next, .interrupt_vector_load, .restart_address,
        .brownout_enable);
    core_model #(.ADDR_WIDTH(16)) core (.pclk, .events, .sleeping, .global_interrupt_enable,
        .fetch_execute, .fetch_address, .external_reset_pin_n, .brownout_circuit_ready);

    // ========================================================================
    // tasks
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one APB transfer, held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task expect_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : expect_reg

    // samples the restart outputs one edge after the cause
    task after_cause(input logic exp_req);
        @(posedge pclk);
        res = resume_next;
        vec = interrupt_vector_load;
        ra = restart_address;
        check("reset request", {31'h0, device_reset_request}, {31'h0, exp_req});
    endtask : after_cause

    task fire(input logic [7:0] v, input logic exp_req);
        core.pulse(reset_events_type'(v));
        after_cause(exp_req);
    endtask : fire

    task fetch(input int a, input logic exp_req);
        core.fetch(16'(a));
        after_cause(exp_req);
    endtask : fetch

    // hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    // ========================================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        expect_reg("cause flags", A_FLAGS, 32'h3D);
        expect_reg("violation", A_VIOL, 32'h02);
        expect_reg("sleep status", A_SLEEP, 32'h18);
        expect_reg("reset control", A_CTRL, 32'h01);
        expect_reg("brownout control", A_BOCON, 32'h80);
        expect_reg("unmapped", 12'h640, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        wr(A_FLAGS, 32'hFF);
        after_cause(1'b0);
        expect_reg("forced flags", A_FLAGS, 32'hFF);
        fire(8'h04, 1'b1);
        check("restart address", {16'h0, ra}, 32'h0);
        expect_reg("after instruction", A_FLAGS, 32'hFB);
        fire(8'h40, 1'b1);
        expect_reg("after watchdog", A_FLAGS, 32'hEB);
        expect_reg("sleep after watchdog", A_SLEEP, 32'h08);
        fire(8'h20, 1'b1);
        expect_reg("after window", A_FLAGS, 32'hCB);
        wr(A_FLAGS, 32'h3F);
        fire(8'h02, 1'b1);
        expect_reg("after overflow", A_FLAGS, 32'hBF);
        fire(8'h01, 1'b1);
        expect_reg("after underflow", A_FLAGS, 32'hFF);
        wr(A_CTRL, 32'h0);
        wr(A_FLAGS, 32'h3F);
        fire(8'h02, 1'b0);
        expect_reg("stack disabled", A_FLAGS, 32'h3F);
        wr(A_CTRL, 32'hFF);
        expect_reg("control bits", A_CTRL, 32'h03);
        fetch(PW - PA - 1, 1'b0);
        fetch(PW - PA, 1'b1);
        expect_reg("violation cleared", A_VIOL, 32'h00);
        wr(A_VIOL, 32'hFF);
        expect_reg("violation rearmed", A_VIOL, 32'h02);
        wr(A_CTRL, 32'h01);
        fetch(PW - 1, 1'b0);
        fetch(PW, 1'b1);
        expect_reg("beyond memory", A_VIOL, 32'h00);
        core.pin_reset();
        expect_reg("pin awake flags", A_FLAGS, 32'h37);
        expect_reg("pin awake violation", A_VIOL, 32'h02);
        expect_reg("pin awake sleep", A_SLEEP, 32'h08);
        core.set_state(1'b1, 1'b0, 1'b0);
        fire(8'h08, 1'b0);
        check("plain wake vector", {31'h0, vec}, 32'h0);
        expect_reg("irq wake sleep", A_SLEEP, 32'h10);
        core.set_state(1'b1, 1'b1, 1'b0);
        fire(8'h08, 1'b0);
        check("vector load", {31'h0, vec}, 32'h1);
        check("vector address", {16'h0, ra}, 32'h4);
        fire(8'h10, 1'b0);
        check("watchdog resume", {31'h0, res}, 32'h1);
        expect_reg("watchdog wake sleep", A_SLEEP, 32'h00);
        expect_reg("wake flags", A_FLAGS, 32'h37);
        wr(A_FLAGS, 32'h3F);
        core.pin_reset();
        expect_reg("pin sleep flags", A_FLAGS, 32'h37);
        expect_reg("pin sleep status", A_SLEEP, 32'h10);
        core.set_state(1'b0, 1'b0, 1'b1);
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
            begin
                wr(A_BOCON, {24'h0, s[0], 7'h0});
                brownout_mode_select <= m[1:0];
                repeat (3) @(posedge pclk);
                check("brownout enable", {31'h0, brownout_enable},
                    {31'h0, m >= 2 || (m == 1 && s == 1)});
            end
        wr(A_FLAGS, 32'hFF);
        fire(8'h80, 1'b1);
        expect_reg("after brownout", A_FLAGS, 32'h3E);
        expect_reg("brownout sleep", A_SLEEP, 32'h18);
        expect_reg("ready and enable", A_BOCON, 32'h81);
        expect_reg("brownout violation", A_VIOL, 32'h02);
        report_and_stop();
    end
endmodule : testbench
